/* File: hdl/csense_pkg.sv */
`default_nettype none
package csense_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;
  localparam int CODE_W = 9;
  localparam int CMP_W = 10;
  localparam int THR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_MEAS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_THRESH = 8'h06;
  localparam int BIT_NEW = 9;
  localparam int BIT_STICKY = 10;
  localparam int BIT_LIVE = 11;
  localparam int CLK_PERIOD_NS = 20;
  localparam int POWERUP_SETTLE_NS = 1000;
  localparam int SETTLE_CYCLES =
    (POWERUP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  // Full sensing span expressed in measurement codes
  localparam int SPAN_CODE = 256;
  localparam int PCT_DEN = 100;
  localparam logic [7:0] TRIP_PCT [16] = '{
    8'h32, 8'h38, 8'h3f, 8'h45, 8'h4c, 8'h52, 8'h58, 8'h5f,
    8'h65, 8'h6c, 8'h72, 8'h78, 8'h7f, 8'h85, 8'h8c, 8'h92};
  localparam logic [DATA_W-1:0] DATA_ZERO = 24'h000000;
  localparam logic [THR_W-1:0] THR_ZERO = 4'h0;
  localparam logic [CODE_W-1:0] CODE_ZERO = 9'h000;

  typedef enum logic {SETTLING, RUNNING} phase_t;

  function automatic logic [CMP_W-1:0] trip_code(input logic [THR_W-1:0] lvl);
    return CMP_W'((SPAN_CODE * int'(TRIP_PCT[lvl])) / PCT_DEN);
  endfunction
endpackage
`default_nettype wire

/* File: hdl/current_sensor_status_fault_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module current_sensor_status_fault_regs
  import csense_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [THR_W-1:0] nvm_fault_level_in,
  input wire logic sample_valid_in,
  input wire logic [CODE_W-1:0] sample_code_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic data_valid_out,
  output logic fault_n_out,
  output logic fault_oe_out
);
  phase_t phase_r, phase_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [THR_W-1:0] thresh_r, thresh_nxt;
  logic [CODE_W-1:0] code_r, code_nxt;
  logic new_r, new_nxt;
  logic sticky_r, sticky_nxt;
  logic live_r, live_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic settled, take, over, rd_meas, wr_meas, wr_thresh, sticky_clr;
  logic [DATA_W-1:0] meas_word;

  assign settled = (phase_r == RUNNING);
  assign take = settled && sample_valid_in;
  assign over = {1'b0, sample_code_in} > trip_code(thresh_r);
  assign rd_meas = reg_rd_in && (reg_addr_in == ADDR_MEAS);
  assign wr_meas = reg_wr_in && (reg_addr_in == ADDR_MEAS);
  assign wr_thresh = reg_wr_in && (reg_addr_in == ADDR_THRESH);
  // Clear needs a one at the sticky position and current at or below trip
  assign sticky_clr = wr_meas && reg_wdata_in[BIT_STICKY] && !live_r
                      && !(take && over);

  always_comb begin
    meas_word = DATA_ZERO;
    meas_word[CODE_W-1:0] = code_r;
    meas_word[BIT_NEW] = new_r;
    meas_word[BIT_STICKY] = sticky_r;
    meas_word[BIT_LIVE] = live_r;
  end

  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    case (phase_r)
      SETTLING: begin
        if (cnt_r == SETTLE_LAST) begin
          phase_nxt = RUNNING;
        end else begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
      end
      RUNNING: begin
        cnt_nxt = cnt_r;
      end
      default: begin
        phase_nxt = SETTLING;
        cnt_nxt = CNT_ZERO;
      end
    endcase
  end

  always_comb begin
    thresh_nxt = wr_thresh ? reg_wdata_in[THR_W-1:0] : thresh_r;
    code_nxt = take ? sample_code_in : code_r;
    live_nxt = take ? over : live_r;
    if (take) begin
      new_nxt = 1'b1;
    end else if (rd_meas) begin
      new_nxt = 1'b0;
    end else begin
      new_nxt = new_r;
    end
    if (take && over) begin
      sticky_nxt = 1'b1;
    end else if (sticky_clr) begin
      sticky_nxt = 1'b0;
    end else begin
      sticky_nxt = sticky_r;
    end
    rvalid_nxt = reg_rd_in;
    rdata_nxt = rdata_r;
    if (reg_rd_in) begin
      if (reg_addr_in == ADDR_MEAS) begin
        rdata_nxt = meas_word;
      end else if (reg_addr_in == ADDR_THRESH) begin
        rdata_nxt = {{(DATA_W-THR_W){1'b0}}, thresh_r};
      end else begin
        rdata_nxt = DATA_ZERO;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      phase_r <= SETTLING;
      cnt_r <= CNT_ZERO;
      thresh_r <= nvm_fault_level_in;
      code_r <= CODE_ZERO;
      new_r <= 1'b0;
      sticky_r <= 1'b0;
      live_r <= 1'b0;
      rdata_r <= DATA_ZERO;
      rvalid_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      thresh_r <= thresh_nxt;
      code_r <= code_nxt;
      new_r <= new_nxt;
      sticky_r <= sticky_nxt;
      live_r <= live_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign data_valid_out = settled;
  assign fault_oe_out = live_r;
  assign fault_n_out = ~live_r;

  sequence s_over_sample;
    take && over;
  endsequence
  sequence s_both_flags;
    sticky_r && live_r;
  endsequence

  property p_nvm_load;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      !$past(rst_n_in) |-> thresh_r == $past(nvm_fault_level_in);
  endproperty
  a_nvm_load: assert property (p_nvm_load)
    else $error("threshold not loaded from default at reset");

  property p_thresh_write;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      wr_thresh |=> thresh_r == $past(reg_wdata_in[THR_W-1:0]);
  endproperty
  a_thresh_write: assert property (p_thresh_write)
    else $error("threshold write did not take effect");

  property p_new_set;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      take |=> new_r ##0 code_r == $past(sample_code_in);
  endproperty
  a_new_set: assert property (p_new_set)
    else $error("new sample flag or code not updated");

  property p_new_clear;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      rd_meas && !take |=> !new_r;
  endproperty
  a_new_clear: assert property (p_new_clear)
    else $error("new sample flag not cleared by read");

  property p_over_sets;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_over_sample |=> s_both_flags;
  endproperty
  a_over_sets: assert property (p_over_sets)
    else $error("overcurrent did not set both flags");

  property p_live_follow;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      take |=> live_r == ({1'b0, $past(sample_code_in)} >
                          trip_code($past(thresh_r)));
  endproperty
  a_live_follow: assert property (p_live_follow)
    else $error("live flag does not match comparison");

  property p_sticky_fall;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(sticky_r) |-> $past(wr_meas) &&
        $past(reg_wdata_in[BIT_STICKY]) && !$past(live_r);
  endproperty
  a_sticky_fall: assert property (p_sticky_fall)
    else $error("sticky flag cleared without valid clear");

  property p_alert;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      fault_oe_out == live_r && fault_oe_out != fault_n_out;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert pin disagrees with live flag");

  property p_settle;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      !settled |-> !live_r && !sticky_r && !new_r && !fault_oe_out;
  endproperty
  a_settle: assert property (p_settle)
    else $error("flags active before settle time");

  property p_reserved;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_rdata_out[DATA_W-1:BIT_LIVE+1] == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved read bits not zero");

  // Code and live flag move only with an accepted sample, never by a write
  property p_live_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      !take |=> $stable(live_r) && $stable(code_r);
  endproperty
  a_live_hold: assert property (p_live_hold)
    else $error("code or live flag changed without a sample");

  property p_settle_len;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(settled) |-> $past(cnt_r) == SETTLE_LAST;
  endproperty
  a_settle_len: assert property (p_settle_len)
    else $error("settle time length wrong");
endmodule
`default_nettype wire

/* File: verif/reg_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
module reg_bus_master
  import csense_pkg::*;
(
  input wire logic clk_in,
  input wire logic [DATA_W-1:0] rdata_in,
  input wire logic rvalid_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic wr_out,
  output logic [DATA_W-1:0] wdata_out,
  output logic rd_out
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = DATA_ZERO;
    rd_out = 1'b0;
  end
  // Whole 24-bit word per write; idle lines show inverted data
  task automatic write_reg(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [23:0] d,
                          output bit ok);
    ok = 1'b0;
    d = DATA_ZERO;
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        d = rdata_in;
      end else begin
        @(posedge clk_in);
        #1;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/current_sensor_status_fault_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module current_sensor_status_fault_regs_test
  import csense_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, sv = 1'b0;
  logic [3:0] nvm = 4'h0;
  logic [8:0] sc = 9'h000;
  logic [7:0] addr;
  logic wr, rd, rvalid, dv, fn, foe;
  logic [23:0] wdata, rdata;
  int num_errors = 0, num_checks = 0;
  localparam int pct [16] = '{50, 56, 63, 69, 76, 82, 88, 95, 101, 108,
                              114, 120, 127, 133, 140, 146};
  initial forever #10 clk = ~clk;
  current_sensor_status_fault_regs u_current_sensor_status_fault_regs (
    .sys_clk_in(clk), .rst_n_in(rst_n), .nvm_fault_level_in(nvm),
    .sample_valid_in(sv), .sample_code_in(sc), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .data_valid_out(dv), .fault_n_out(fn), .fault_oe_out(foe));
  reg_bus_master u_reg_bus_master (.clk_in(clk), .rdata_in(rdata),
    .rvalid_in(rvalid), .addr_out(addr), .wr_out(wr),
    .wdata_out(wdata), .rd_out(rd));
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_word(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic check_bit(input logic g, input logic e);
    check_word({23'h0, g}, {23'h0, e});
  endtask
  task automatic w(input logic [7:0] a, input logic [23:0] d);
    u_reg_bus_master.write_reg(a, d);
  endtask
  task automatic r(input logic [7:0] a, input logic [23:0] e);
    logic [23:0] d;
    bit ok;
    u_reg_bus_master.read_reg(a, d, ok);
    if (!ok) begin
      num_errors++;
      stop_test();
    end
    check_word(d, e);
  endtask
  task automatic sample(input logic [8:0] c);
    @(posedge clk);
    sv <= 1'b1;
    sc <= c;
    @(posedge clk);
    sv <= 1'b0;
    #1;
  endtask
  task automatic do_reset(input logic [3:0] lvl);
    @(posedge clk);
    nvm <= lvl;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wait_valid();
    for (int i = 0; i < 100 && dv !== 1'b1; i++) @(posedge clk);
    if (dv !== 1'b1) begin
      num_errors++;
      stop_test();
    end
  endtask
  initial begin
    int t;
    do_reset(4'h9);
    #1;
    check_bit(dv, 1'b0);
    r(ADDR_THRESH, 24'h000009);
    sample(9'h1ff);
    wait_valid();
    r(ADDR_MEAS, DATA_ZERO);
    w(ADDR_THRESH, 24'hffffff);
    r(ADDR_THRESH, 24'h00000f);
    w(ADDR_THRESH, DATA_ZERO);
    sample(9'h080);
    r(ADDR_MEAS, 24'h000280);
    r(ADDR_MEAS, 24'h000080);
    sample(9'h129);
    check_bit(fn, 1'b0);
    check_bit(foe, 1'b1);
    r(ADDR_MEAS, 24'h000f29);
    w(ADDR_MEAS, 24'hfff400);
    r(ADDR_MEAS, 24'h000d29);
    sample(9'h050);
    check_bit(fn, 1'b1);
    check_bit(foe, 1'b0);
    r(ADDR_MEAS, 24'h000650);
    w(ADDR_MEAS, 24'h000400);
    r(ADDR_MEAS, 24'h000050);
    r(8'h02, DATA_ZERO);
    for (int l = 0; l < 16; l++) begin
      w(ADDR_THRESH, 24'(l));
      t = (256 * pct[l]) / 100;
      sample(9'(t));
      check_bit(fn, 1'b1);
      sample(9'(t + 1));
      check_bit(fn, 1'b0);
    end
    do_reset(4'h3);
    r(ADDR_THRESH, 24'h000003);
    r(ADDR_MEAS, DATA_ZERO);
    stop_test();
  end
endmodule
`default_nettype wire
